// ===== rtl/aiv_int_vector.sv
// aiv_int_vector: flag, enable, vector and dma trigger logic of the
// converter peripheral, with its 16-bit register map.
// assumes the sequencer gives one-cycle event pulses and that the
// result memories report each access as a pulse with the slot index.
//
// Functional notes
// - thirty-eight sources: 32 slot flags, overwrite, overrun, three window, ref ready.
// - a slot's result-ready flag sets when a result loads into it.
// - request rises only for a flag whose enable is set; cpu gates globally.
// - a result load also updates the window flags when the slot checks.
// - overwrite flag sets when a slot is loaded before its last read.
// - overrun flag sets when a convert request arrives while busy.
// - dma trigger per conversion, or per finished sequence in sequence mode.
// - ref ready flag sets once the reference buffer reports settled.
// - all sources are prioritised into one request and one vector word.
// - vector shows highest enabled pending source; disabled sources ignored.
// - vector read clears that source, unless it is a slot flag.
// - slot flag clears on slot access, or by software flag write.
// - any write to the vector word clears every flag except those set in the same cycle.
// - request stays and vector moves on while other sources pend.
// - vector codes: 0 none, 2, 4, 6 above, 8 below, A inside.
// - word and byte access; low byte bits 0-7, high byte 8-15.
// - below under low, above over high, inside strictly between.
// - changing data format or resolution resets both thresholds.
`timescale 1ns/1ps

module aiv_int_vector (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // register bus
    input  wire aiv_pkg::aiv_bus_req_s   bus_req,
    output logic [15:0]                  bus_rdata,
    // conversion events
    input  wire aiv_pkg::aiv_result_ev_s result_ev,
    input  wire logic                    slot_access,
    input  wire logic [4:0]              slot_access_idx,
    input  wire logic                    convert_request,
    input  wire logic                    conv_busy,
    input  wire logic                    conv_done,
    input  wire logic                    sequence_end,
    input  wire logic                    ref_buffer_settled,
    // outputs to cpu and dma
    output logic                         int_request,
    output logic                         dma_trigger,
    output logic [15:0]                  data_format_mode,
    output logic [15:0]                  int_vector_word
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [15:0]                   ctl0;
    logic [15:0]                   ctl1;
    logic [15:0]                   ctl2;
    logic [15:0]                   ctl3;
    logic [15:0]                   win_lo;
    logic [15:0]                   win_hi;
    logic [aiv_pkg::NUM_SRC-1:0]   flags;
    logic [47:0]                   enables;
    logic [5:0]                    cur_src;
    logic [aiv_pkg::NUM_SLOTS-1:0] unread;
    logic                          ref_settled_q;

    // ************************************************************
    // bus decode
    // ************************************************************
    logic [15:0] bmask;
    logic        wr_ctl0;
    logic        wr_ctl1;
    logic        wr_ctl2;
    logic        wr_ctl3;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_vec;
    logic        rd_vec;
    logic [15:0] next_ctl2;
    logic        fmt_change;

    // byte enables select the low or high half of a word
    assign bmask   = {{8{bus_req.be[1]}}, {8{bus_req.be[0]}}};
    assign wr_ctl0 = bus_req.wr && bus_req.addr == aiv_pkg::OFS_CTL0;
    assign wr_ctl1 = bus_req.wr && bus_req.addr == aiv_pkg::OFS_CTL1;
    assign wr_ctl2 = bus_req.wr && bus_req.addr == aiv_pkg::OFS_CTL2;
    assign wr_ctl3 = bus_req.wr && bus_req.addr == aiv_pkg::OFS_CTL3;
    assign wr_lo   = bus_req.wr && bus_req.addr == aiv_pkg::OFS_WIN_LO;
    assign wr_hi   = bus_req.wr && bus_req.addr == aiv_pkg::OFS_WIN_HI;
    assign wr_vec  = bus_req.wr && bus_req.addr == aiv_pkg::OFS_VECTOR;
    assign rd_vec  = bus_req.rd && bus_req.addr == aiv_pkg::OFS_VECTOR;

    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    assign next_ctl2  = wr_ctl2 ? merge(ctl2, bus_req.wdata, bmask) : ctl2;
    // a format or resolution change makes old thresholds meaningless
    assign fmt_change =
        next_ctl2[aiv_pkg::CTL2_DF_BIT] != ctl2[aiv_pkg::CTL2_DF_BIT] ||
        next_ctl2[aiv_pkg::CTL2_RES_LSB +: 2] !=
            ctl2[aiv_pkg::CTL2_RES_LSB +: 2];

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl0 <= aiv_pkg::RST_CTL0;
            ctl1 <= aiv_pkg::RST_CTL1;
            ctl2 <= aiv_pkg::RST_CTL2;
            ctl3 <= aiv_pkg::RST_CTL3;
        end else begin
            if (wr_ctl0) begin
                ctl0 <= merge(ctl0, bus_req.wdata, bmask);
            end
            if (wr_ctl1) begin
                ctl1 <= merge(ctl1, bus_req.wdata, bmask);
            end
            ctl2 <= next_ctl2;
            if (wr_ctl3) begin
                ctl3 <= merge(ctl3, bus_req.wdata, bmask);
            end
        end
    end

    assign data_format_mode = ctl2;

    // ************************************************************
    // window thresholds
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_lo <= aiv_pkg::RST_WIN_LO;
            win_hi <= aiv_pkg::RST_WIN_HI;
        end else if (fmt_change) begin
            win_lo <= aiv_pkg::RST_WIN_LO;
            win_hi <= aiv_pkg::RST_WIN_HI;
        end else begin
            if (wr_lo) begin
                win_lo <= merge(win_lo, bus_req.wdata, bmask);
            end
            if (wr_hi) begin
                win_hi <= merge(win_hi, bus_req.wdata, bmask);
            end
        end
    end

    // ************************************************************
    // window comparison
    // ************************************************************
    logic               df_signed;
    logic signed [16:0] res_x;
    logic signed [16:0] lo_x;
    logic signed [16:0] hi_x;
    logic               win_en;

    // extend by one bit so a single signed compare serves both formats
    assign df_signed = ctl2[aiv_pkg::CTL2_DF_BIT];
    assign res_x = {df_signed & result_ev.value[15], result_ev.value};
    assign lo_x  = {df_signed & win_lo[15], win_lo};
    assign hi_x  = {df_signed & win_hi[15], win_hi};
    assign win_en = result_ev.load && result_ev.win_check;

    // ************************************************************
    // flag set, clear and software write terms
    // ************************************************************
    logic [aiv_pkg::NUM_SRC-1:0] set_v;
    logic [aiv_pkg::NUM_SRC-1:0] clr_v;
    logic [aiv_pkg::NUM_SRC-1:0] swm_v;
    logic [aiv_pkg::NUM_SRC-1:0] swd_v;
    logic [aiv_pkg::NUM_SRC-1:0] enm_v;
    logic [aiv_pkg::NUM_SRC-1:0] flag_pend;
    logic [15:0]                 vec_code;
    logic [5:0]                  vec_src;
    logic                        vec_valid;
    logic                        ovw_hit;

    assign ovw_hit = result_ev.load && unread[result_ev.slot];

    // ************************************************************
    // per-slot events
    // ************************************************************
    logic [aiv_pkg::NUM_SLOTS-1:0] slot_set;
    logic [aiv_pkg::NUM_SLOTS-1:0] slot_clr;
    for (genvar gi = 0; gi < aiv_pkg::NUM_SLOTS; gi++) begin : g_slot
        assign slot_set[gi] = result_ev.load && result_ev.slot == 5'(gi);
        assign slot_clr[gi] = slot_access && slot_access_idx == 5'(gi);
    end

    // ************************************************************
    // event history
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unread        <= '0;
            ref_settled_q <= 1'b0;
        end else begin
            // a load beside an access of the same slot keeps it unread
            unread        <= (unread & ~slot_clr) | slot_set;
            ref_settled_q <= ref_buffer_settled;
        end
    end

    // ************************************************************
    // flag and enable register writes
    // ************************************************************
    logic                        wr_flag0;
    logic                        wr_flag1;
    logic                        wr_flag2;
    logic [47:0]                 next_enables;
    logic [aiv_pkg::NUM_SRC-1:0] next_flags;
    assign wr_flag0 = bus_req.wr && bus_req.addr == aiv_pkg::OFS_FLAG0;
    assign wr_flag1 = bus_req.wr && bus_req.addr == aiv_pkg::OFS_FLAG1;
    assign wr_flag2 = bus_req.wr && bus_req.addr == aiv_pkg::OFS_FLAG2;
    // software may set or clear any flag directly
    assign swm_v = {wr_flag2 ? bmask[5:0] : 6'h00,
                    wr_flag1 ? bmask : 16'h0000,
                    wr_flag0 ? bmask : 16'h0000};
    assign swd_v = {bus_req.wdata[5:0], bus_req.wdata, bus_req.wdata};
    always_comb begin
        next_enables = enables;
        if (bus_req.wr && bus_req.addr == aiv_pkg::OFS_EN0) begin
            next_enables[15:0] = merge(enables[15:0], bus_req.wdata, bmask);
        end
        if (bus_req.wr && bus_req.addr == aiv_pkg::OFS_EN1) begin
            next_enables[31:16] = merge(enables[31:16], bus_req.wdata, bmask);
        end
        if (bus_req.wr && bus_req.addr == aiv_pkg::OFS_EN2) begin
            next_enables[47:32] = merge(enables[47:32], bus_req.wdata, bmask);
        end
    end
    assign enm_v = next_enables[aiv_pkg::NUM_SRC-1:0];

    // ************************************************************
    // flag set, clear and next value
    // ************************************************************
    always_comb begin
        set_v = '0;
        set_v[aiv_pkg::NUM_SLOTS-1:0] = slot_set;
        set_v[aiv_pkg::SRC_BELOW]     = win_en && res_x < lo_x;
        set_v[aiv_pkg::SRC_INSIDE]    = win_en && res_x > lo_x
                                        && res_x < hi_x;
        set_v[aiv_pkg::SRC_ABOVE]     = win_en && res_x > hi_x;
        set_v[aiv_pkg::SRC_OVERWRITE] = ovw_hit;
        set_v[aiv_pkg::SRC_OVERRUN]   = convert_request && conv_busy;
        // edge, not level, so a cleared flag stays clear while settled
        set_v[aiv_pkg::SRC_REF_READY] = ref_buffer_settled
                                        && !ref_settled_q;
        clr_v = '0;
        clr_v[aiv_pkg::NUM_SLOTS-1:0] = slot_clr;
        // a vector read releases the source it reported, never a slot
        if (rd_vec && int_request && cur_src >= 6'(aiv_pkg::NUM_SLOTS)) begin
            clr_v[cur_src] = 1'b1;
        end
        next_flags = '0;
        if (!wr_vec) begin
            next_flags = ((flags & ~swm_v) | (swd_v & swm_v)) & ~clr_v;
        end
        next_flags = next_flags | set_v;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags   <= '0;
            enables <= '0;
        end else begin
            flags   <= next_flags;
            enables <= next_enables;
        end
    end

    // ************************************************************
    // priority encoder
    // ************************************************************
    // fed by next state so stored vector and request match the flags
    assign flag_pend = next_flags & enm_v;
    assign vec_valid = |flag_pend;
    always_comb begin
        vec_code = aiv_pkg::VEC_NONE;
        vec_src  = 6'h00;
        if (flag_pend[aiv_pkg::SRC_REF_READY]) begin
            vec_code = aiv_pkg::VEC_REF_READY;
            vec_src  = 6'(aiv_pkg::SRC_REF_READY);
        end
        for (int i = aiv_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
            if (flag_pend[i]) begin
                vec_code = aiv_pkg::VEC_SLOT_BASE + 16'(2 * i);
                vec_src  = 6'(i);
            end
        end
        if (flag_pend[aiv_pkg::SRC_INSIDE]) begin
            vec_code = aiv_pkg::VEC_INSIDE;
            vec_src  = 6'(aiv_pkg::SRC_INSIDE);
        end
        if (flag_pend[aiv_pkg::SRC_BELOW]) begin
            vec_code = aiv_pkg::VEC_BELOW;
            vec_src  = 6'(aiv_pkg::SRC_BELOW);
        end
        if (flag_pend[aiv_pkg::SRC_ABOVE]) begin
            vec_code = aiv_pkg::VEC_ABOVE;
            vec_src  = 6'(aiv_pkg::SRC_ABOVE);
        end
        if (flag_pend[aiv_pkg::SRC_OVERRUN]) begin
            vec_code = aiv_pkg::VEC_OVERRUN;
            vec_src  = 6'(aiv_pkg::SRC_OVERRUN);
        end
        if (flag_pend[aiv_pkg::SRC_OVERWRITE]) begin
            vec_code = aiv_pkg::VEC_OVERWRITE;
            vec_src  = 6'(aiv_pkg::SRC_OVERWRITE);
        end
    end

    // ************************************************************
    // request, vector and dma trigger
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_vector_word <= aiv_pkg::VEC_NONE;
            cur_src         <= 6'h00;
            int_request     <= 1'b0;
        end else begin
            int_vector_word <= vec_code;
            cur_src         <= vec_src;
            int_request     <= vec_valid;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_trigger <= 1'b0;
        end else if (ctl1[aiv_pkg::CTL1_SEQ_BIT]) begin
            dma_trigger <= sequence_end;
        end else begin
            dma_trigger <= conv_done;
        end
    end

    // ************************************************************
    // register read
    // ************************************************************
    // registered data stands the cycle after the request; reserved reads 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 16'h0000;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                aiv_pkg::OFS_CTL0:   bus_rdata <= ctl0;
                aiv_pkg::OFS_CTL1:   bus_rdata <= ctl1;
                aiv_pkg::OFS_CTL2:   bus_rdata <= ctl2;
                aiv_pkg::OFS_CTL3:   bus_rdata <= ctl3;
                aiv_pkg::OFS_WIN_LO: bus_rdata <= win_lo;
                aiv_pkg::OFS_WIN_HI: bus_rdata <= win_hi;
                aiv_pkg::OFS_FLAG0:  bus_rdata <= flags[15:0];
                aiv_pkg::OFS_FLAG1:  bus_rdata <= flags[31:16];
                aiv_pkg::OFS_FLAG2:  bus_rdata <= {10'h000, flags[37:32]};
                aiv_pkg::OFS_EN0:    bus_rdata <= enables[15:0];
                aiv_pkg::OFS_EN1:    bus_rdata <= enables[31:16];
                aiv_pkg::OFS_EN2:    bus_rdata <= enables[47:32];
                aiv_pkg::OFS_VECTOR: bus_rdata <= int_vector_word;
                default:             bus_rdata <= 16'h0000;
            endcase
        end
    end

endmodule

// ===== rtl/aiv_pkg.sv
// aiv_pkg: constants and carrier types of the converter interrupt block.
// assumes a 16-bit peripheral register bus with byte enables.
package aiv_pkg;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_CTL0     = 8'h00;
    localparam logic [7:0] OFS_CTL1     = 8'h02;
    localparam logic [7:0] OFS_CTL2     = 8'h04;
    localparam logic [7:0] OFS_CTL3     = 8'h06;
    localparam logic [7:0] OFS_WIN_LO   = 8'h08;
    localparam logic [7:0] OFS_WIN_HI   = 8'h0A;
    localparam logic [7:0] OFS_FLAG0    = 8'h0C;
    localparam logic [7:0] OFS_FLAG1    = 8'h0E;
    localparam logic [7:0] OFS_FLAG2    = 8'h10;
    localparam logic [7:0] OFS_EN0      = 8'h12;
    localparam logic [7:0] OFS_EN1      = 8'h14;
    localparam logic [7:0] OFS_EN2      = 8'h16;
    localparam logic [7:0] OFS_VECTOR   = 8'h18;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] RST_CTL0    = 16'h0000;
    localparam logic [15:0] RST_CTL1    = 16'h0000;
    localparam logic [15:0] RST_CTL2    = 16'h0020;
    localparam logic [15:0] RST_CTL3    = 16'h0000;
    localparam logic [15:0] RST_WIN_LO  = 16'h0000;
    localparam logic [15:0] RST_WIN_HI  = 16'h0FFF;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTL1_SEQ_BIT   = 1;  // sequence-of-channels mode
    localparam int CTL2_DF_BIT    = 3;  // data_format_select
    localparam int CTL2_RES_LSB   = 4;  // resolution_select, 2 bits
    localparam int NUM_SLOTS      = 32;
    localparam int NUM_SRC        = 38;
    // source index in the flag vector; 32..37 are flag_register_2 bits
    localparam int SRC_BELOW      = 32;
    localparam int SRC_INSIDE     = 33;
    localparam int SRC_ABOVE      = 34;
    localparam int SRC_OVERWRITE  = 35;
    localparam int SRC_OVERRUN    = 36;
    localparam int SRC_REF_READY  = 37;

    // ************************************************************
    // vector codes
    // ************************************************************
    localparam logic [15:0] VEC_NONE      = 16'h0000;
    localparam logic [15:0] VEC_OVERWRITE = 16'h0002;
    localparam logic [15:0] VEC_OVERRUN   = 16'h0004;
    localparam logic [15:0] VEC_ABOVE     = 16'h0006;
    localparam logic [15:0] VEC_BELOW     = 16'h0008;
    localparam logic [15:0] VEC_INSIDE    = 16'h000A;
    localparam logic [15:0] VEC_SLOT_BASE = 16'h000C;
    localparam logic [15:0] VEC_REF_READY = 16'h0076;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } aiv_bus_req_s;

    typedef struct packed {
        logic        load;
        logic [4:0]  slot;
        logic [15:0] value;
        logic        win_check;
    } aiv_result_ev_s;

endpackage

// ===== dv/aiv_int_vector_monitor.sv
// checker of the vector block, bound to its top ports
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module aiv_monitor (
    // watched ports
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire aiv_pkg::aiv_bus_req_s   bus_req,
    input wire aiv_pkg::aiv_result_ev_s result_ev,
    input wire logic                    slot_access,
    input wire logic                    convert_request,
    input wire logic                    conv_done,
    input wire logic                    sequence_end,
    input wire logic                    ref_buffer_settled,
    input wire logic                    int_request,
    input wire logic                    dma_trigger,
    input wire logic [15:0]             int_vector_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic idle, quiet, vrd, vwr;
    // no event that could raise a flag this cycle
    assign idle = !result_ev.load && !slot_access && !convert_request
        && !ref_buffer_settled;
    assign quiet = idle && !bus_req.wr;
    assign vrd = bus_req.rd && bus_req.addr == aiv_pkg::OFS_VECTOR;
    assign vwr = bus_req.wr && bus_req.addr == aiv_pkg::OFS_VECTOR;
    req_vec_a: assert property (
        int_request == (int_vector_word != 16'h0000))
        else $error("request and vector disagree");
    code_even_a: assert property (
        !int_vector_word[0] && int_vector_word <= 16'h0076)
        else $error("vector code out of range");
    wr_clear_a: assert property (
        vwr && idle |=> int_vector_word == 16'h0000)
        else $error("vector write left flags");
    rd_clear_a: assert property (
        vrd && quiet && int_vector_word inside {[16'h0002:16'h000A]}
        |=> int_vector_word != $past(int_vector_word))
        else $error("vector read kept source");
    rd_keep_a: assert property (
        vrd && quiet && int_vector_word inside {[16'h000C:16'h0074]}
        |=> $stable(int_vector_word))
        else $error("vector read cleared slot");
    hold_a: assert property (
        quiet && !bus_req.rd |=> $stable(int_vector_word))
        else $error("vector moved with no cause");
    dma_cause_a: assert property (
        dma_trigger |-> conv_done || sequence_end
        || $past(conv_done) || $past(sequence_end))
        else $error("dma trigger without completion");
    rst_idle_a: assert property (
        $rose(rst_n) |-> int_vector_word == 16'h0000)
        else $error("vector not idle after reset");
endmodule
bind aiv_int_vector aiv_monitor u_aiv_monitor (.clk(clk), .rst_n(rst_n),
    .bus_req(bus_req), .result_ev(result_ev), .slot_access(slot_access),
    .convert_request(convert_request), .conv_done(conv_done),
    .sequence_end(sequence_end), .ref_buffer_settled(ref_buffer_settled),
    .int_request(int_request), .dma_trigger(dma_trigger),
    .int_vector_word(int_vector_word));

// ===== dv/aiv_cpu_model.sv
// cpu model: register bus master and the global interrupt gate
// assumes requests taken on the rising edge after a falling edge
`timescale 1ns/1ps
module aiv_cpu_model (
    // bus and request
    input  wire logic             clk,
    input  wire logic [15:0]      bus_rdata,
    input  wire logic             int_request,
    output aiv_pkg::aiv_bus_req_s bus_req,
    output logic                  irq_taken
);
    logic global_int_enable = 1'h1;
    assign irq_taken = int_request && global_int_enable;
    initial bus_req = '0;
    // callers pass mapped offsets only; released lines show inverted data
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [1:0] be, input logic [15:0] d, output logic [15:0] r);
        bus_req = '{!w, w, a, be, d};
        @(negedge clk);
        r = bus_rdata;
        bus_req = '{1'h0, 1'h0, ~a, be, ~d};
        @(negedge clk);
    endtask
endmodule

// ===== dv/tb_adc_interrupt_vector_logic.sv
// self-checking bench of the converter interrupt vector block
// assumes the cpu model owns the bus; events change at falling edges
`timescale 1ns/1ps
module tb_adc_interrupt_vector_logic;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    aiv_pkg::aiv_bus_req_s bus_req;
    aiv_pkg::aiv_result_ev_s ev = '0;
    logic [15:0] rdata, vec, dfm, q;
    logic sa = 1'h0, cr = 1'h0, busy = 1'h0;
    logic cd = 1'h0, se = 1'h0, rs = 1'h0, irq, dma;
    logic [4:0] sai = 5'h00;
    logic [31:0] rng = 32'h0001_3668;
    int n_fail = 0, checked = 0, n_dma = 0, n;
    always #25 clk = ~clk;
    always @(posedge clk) if (dma === 1'h1) n_dma++;
    aiv_int_vector u_aiv_int_vector (.clk(clk), .rst_n(rst_n),
        .bus_req(bus_req), .bus_rdata(rdata), .result_ev(ev),
        .slot_access(sa), .slot_access_idx(sai), .convert_request(cr),
        .conv_busy(busy), .conv_done(cd), .sequence_end(se),
        .ref_buffer_settled(rs), .int_request(irq), .dma_trigger(dma),
        .data_format_mode(dfm), .int_vector_word(vec));
    aiv_cpu_model u_aiv_cpu_model (.clk(clk), .bus_rdata(rdata),
        .int_request(irq), .bus_req(bus_req), .irq_taken());
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_aiv_cpu_model.acc(1'h1, a, 2'h3, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        u_aiv_cpu_model.acc(1'h0, a, 2'h3, 16'h0000, q);
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge clk);
        s = 1'h0;
        @(negedge clk);
    endtask
    task automatic load(input int k, input logic w, input logic [15:0] v);
        ev = '{1'h1, 5'(k), v, w};
        @(negedge clk);
        ev = '{1'h0, ~5'(k), ~v, ~w};
        @(negedge clk);
    endtask
    function automatic logic [15:0] slot_vec(input int k);
        return aiv_pkg::VEC_SLOT_BASE + 16'(2 * k);
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic results;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #1_000_000;
        n_fail++;
        results();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        for (int a = 0; a < 24; a += 2) begin
            rd(8'(a));
            chk(q, a == 4 ? 16'h0020 : a == 10 ? 16'h0FFF : 16'h0000);
            if (a > 16) wr(8'(a), 16'hFFFF);
        end
        // low byte only: disables the six extra sources
        u_aiv_cpu_model.acc(1'h1, aiv_pkg::OFS_EN2, 2'h1, 16'h0000, q);
        rd(aiv_pkg::OFS_EN2);
        chk(q, 16'hFF00);
        busy = 1'h1;
        pulse(cr);
        busy = 1'h0;
        chk(vec, aiv_pkg::VEC_NONE);
        wr(aiv_pkg::OFS_EN2, 16'hFFFF);
        chk(vec, aiv_pkg::VEC_OVERRUN);
        wr(aiv_pkg::OFS_WIN_LO, 16'h0123);
        wr(aiv_pkg::OFS_CTL2, 16'h0028);
        chk(dfm, 16'h0028);
        rd(aiv_pkg::OFS_WIN_LO);
        chk(q, 16'h0000);
        load(3, 1'h1, 16'h0100);
        pulse(rs);
        rd(aiv_pkg::OFS_VECTOR);
        chk(q, aiv_pkg::VEC_OVERRUN);
        chk(vec, aiv_pkg::VEC_INSIDE);
        rd(aiv_pkg::OFS_VECTOR);
        rd(aiv_pkg::OFS_VECTOR);
        chk(vec, slot_vec(3));
        sai = 5'h03;
        pulse(sa);
        chk(vec, aiv_pkg::VEC_REF_READY);
        load(5, 1'h0, 16'h0001);
        load(5, 1'h0, 16'h0002);
        chk(vec, aiv_pkg::VEC_OVERWRITE);
        sai = 5'h05;
        pulse(sa);
        wr(aiv_pkg::OFS_VECTOR, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        wr(aiv_pkg::OFS_FLAG2, 16'h0002);
        chk(vec, aiv_pkg::VEC_INSIDE);
        wr(aiv_pkg::OFS_FLAG2, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            rng = xs(rng);
            n = int'(rng[4:0]);
            load(n, 1'h0, rng[31:16]);
            chk(vec, slot_vec(n));
            sai = 5'(n);
            pulse(sa);
            chk(vec, aiv_pkg::VEC_NONE);
        end
        pulse(cd);
        chk(16'(n_dma), 16'h0001);
        wr(aiv_pkg::OFS_CTL1, 16'h0002);
        pulse(cd);
        chk(16'(n_dma), 16'h0001);
        pulse(se);
        chk(16'(n_dma), 16'h0002);
        results();
    end
endmodule
